// file: core/gpcs_decoder.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
module general_purpose_chip_select_decoder
   import chip_select_pkg::*;
#(
   parameter int NUM_CHAN = 3,
   parameter int ADDR_W   = 32
)
(
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rst_b_in,
   // ahb-lite slave
   input  wire logic              hsel_in,
   input  wire logic [ADDR_W-1:0] haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [2:0]        hsize_in,
   input  wire logic [31:0]       hwdata_in,
   input  wire logic              hready_in,
   output logic [31:0]            hrdata_out,
   output logic                   hreadyout_out,
   output logic                   hresp_out,
   // peripheral access
   input  wire logic [15:0]       la_in,
   input  wire logic              io_access_in,
   // decoded selects
   output logic [2:0]             periph_select_n_out,
   output logic [2:0]             encoded_select_lines_out,
   output logic                   xbus_transceiver_oe_n_out
);
   if (NUM_CHAN != 3) begin : g_bad_chan
      $error("decoder serves exactly three channels");
   end

   if (XBUS_EN_W != NUM_CHAN) begin : g_bad_xbus
      $error("decoder needs one x-bus enable per channel");
   end

   if (ADDR_W <= IDX_MSB) begin : g_bad_addr
      $error("decoder needs an address wider than the index");
   end

   // bus data-phase state
   logic       wr_pend_r;
   logic [7:0] wr_idx_r;
   logic       wr_go;

   // write strobes
   logic [NUM_CHAN-1:0] wr_low;
   logic [NUM_CHAN-1:0] wr_high;
   logic [NUM_CHAN-1:0] wr_mask;
   logic                wr_xbus;
   logic                wr_mode;
   logic                wr_format;

   // read selects
   logic [NUM_CHAN-1:0] rd_low;
   logic [NUM_CHAN-1:0] rd_high;
   logic [NUM_CHAN-1:0] rd_mask;
   logic                rd_xbus;
   logic                rd_mode;
   logic                rd_format;

   // registers
   logic [7:0]           low_addr_r  [NUM_CHAN];
   logic [7:0]           high_addr_r [NUM_CHAN];
   logic [7:0]           low_mask_r  [NUM_CHAN];
   logic [7:0]           low_addr_nxt  [NUM_CHAN];
   logic [7:0]           high_addr_nxt [NUM_CHAN];
   logic [7:0]           low_mask_nxt  [NUM_CHAN];
   logic [XBUS_EN_W-1:0] xbus_en_r;
   logic [XBUS_EN_W-1:0] xbus_en_nxt;
   logic [7:0]           mode_sel_r;
   logic [7:0]           mode_sel_nxt;
   logic                 format_r;
   logic                 format_nxt;

   // read path
   logic       rd_take;
   logic [7:0] rd_idx;
   logic [7:0] rd_val;

   // decode path
   logic [NUM_CHAN-1:0] chan_on;
   logic [NUM_CHAN-1:0] hit;
   logic [NUM_CHAN-1:0] xbus_hit;
   logic [2:0]          select_n;
   logic [2:0]          encoded;

   localparam logic [7:0] IDX_LOW  [NUM_CHAN] =
      '{IDX_CH0_LOW_ADDR, IDX_CH1_LOW_ADDR, IDX_CH2_LOW_ADDR};
   localparam logic [7:0] IDX_HIGH [NUM_CHAN] =
      '{IDX_CH0_HIGH_ADDR, IDX_CH1_HIGH_ADDR, IDX_CH2_HIGH_ADDR};
   localparam logic [7:0] IDX_MASK [NUM_CHAN] =
      '{IDX_CH0_MASK, IDX_CH1_MASK, IDX_CH2_MASK};

   // address phase capture
   assign rd_take = hsel_in & hready_in & htrans_in[1]
                    & ~hwrite_in;
   assign rd_idx  = haddr_in[IDX_MSB:IDX_LSB];
   assign wr_go   = wr_pend_r;

   // write pending flag
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         wr_pend_r <= 1'b0;
      end else if (hready_in) begin
         wr_pend_r <= hsel_in & htrans_in[1] & hwrite_in;
      end
   end

   // write index
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         wr_idx_r <= 8'h00;
      end else if (hready_in) begin
         wr_idx_r <= haddr_in[IDX_MSB:IDX_LSB];
      end
   end

   // write strobes, one per register
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         wr_low[i]  = wr_go && (wr_idx_r == IDX_LOW[i]);
         wr_high[i] = wr_go && (wr_idx_r == IDX_HIGH[i]);
         wr_mask[i] = wr_go && (wr_idx_r == IDX_MASK[i]);
      end
      wr_xbus   = wr_go && (wr_idx_r == IDX_XBUS_CTRL);
      wr_mode   = wr_go && (wr_idx_r == IDX_MODE_SELECT);
      wr_format = wr_go && (wr_idx_r == IDX_SELECT_FORMAT);
   end

   // register next values, a write lands in its data phase
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         low_addr_nxt[i]  = low_addr_r[i];
         high_addr_nxt[i] = high_addr_r[i];
         low_mask_nxt[i]  = low_mask_r[i];
         if (wr_low[i]) begin
            low_addr_nxt[i] = hwdata_in[7:0];
         end
         if (wr_high[i]) begin
            high_addr_nxt[i] = hwdata_in[7:0];
         end
         if (wr_mask[i]) begin
            low_mask_nxt[i] = hwdata_in[7:0];
         end
      end
      xbus_en_nxt  = xbus_en_r;
      mode_sel_nxt = mode_sel_r;
      format_nxt   = format_r;
      if (wr_xbus) begin
         xbus_en_nxt = hwdata_in[XBUS_EN_W-1:0];
      end
      if (wr_mode) begin
         mode_sel_nxt = hwdata_in[7:0];
      end
      if (wr_format) begin
         format_nxt = hwdata_in[FORMAT_ENC_BIT];
      end
   end

   // low address bytes
   always_ff @(posedge clk_sys_in) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (!rst_b_in) begin
            low_addr_r[i] <= RST_LOW_ADDR;
         end else begin
            low_addr_r[i] <= low_addr_nxt[i];
         end
      end
   end

   // high address bytes
   always_ff @(posedge clk_sys_in) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (!rst_b_in) begin
            high_addr_r[i] <= RST_HIGH_ADDR;
         end else begin
            high_addr_r[i] <= high_addr_nxt[i];
         end
      end
   end

   // low address masks
   always_ff @(posedge clk_sys_in) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (!rst_b_in) begin
            low_mask_r[i] <= RST_MASK;
         end else begin
            low_mask_r[i] <= low_mask_nxt[i];
         end
      end
   end

   // x-bus enable control
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         xbus_en_r <= RST_XBUS_CTRL;
      end else begin
         xbus_en_r <= xbus_en_nxt;
      end
   end

   // mode select
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         mode_sel_r <= RST_MODE_SEL;
      end else begin
         mode_sel_r <= mode_sel_nxt;
      end
   end

   // select format
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         format_r <= RST_FORMAT;
      end else begin
         format_r <= format_nxt;
      end
   end

   // read selects, one per register
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         rd_low[i]  = (rd_idx == IDX_LOW[i]);
         rd_high[i] = (rd_idx == IDX_HIGH[i]);
         rd_mask[i] = (rd_idx == IDX_MASK[i]);
      end
      rd_xbus   = (rd_idx == IDX_XBUS_CTRL);
      rd_mode   = (rd_idx == IDX_MODE_SELECT);
      rd_format = (rd_idx == IDX_SELECT_FORMAT);
   end

   // read mux on next values so a write just before is seen
   always_comb begin
      rd_val = 8'h00;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (rd_low[i]) begin
            rd_val = low_addr_nxt[i];
         end
         if (rd_high[i]) begin
            rd_val = high_addr_nxt[i];
         end
         if (rd_mask[i]) begin
            rd_val = low_mask_nxt[i];
         end
      end
      if (rd_xbus) begin
         rd_val = {5'h00, xbus_en_nxt};
      end
      if (rd_mode) begin
         rd_val = mode_sel_nxt;
      end
      if (rd_format) begin
         rd_val = {7'h00, format_nxt};
      end
   end

   // bus answer, zero wait states, always okay
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         hreadyout_out <= 1'b1;
         hresp_out     <= HRESP_OKAY;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= HRESP_OKAY;
      end
   end

   // read data, loaded in the address phase
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata_out <= {24'h000000, rd_val};
      end
   end

   // per-channel match
   always_comb begin
      chan_on = '1;
      chan_on[2] = ~mode_sel_r[MODE_CH2_OFF_BIT];
   end

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      chan_match u_match (
         .high_addr_in (high_addr_r[g]),
         .low_addr_in  (low_addr_r[g]),
         .low_mask_in  (low_mask_r[g]),
         .chan_on_in   (chan_on[g]),
         .la_in        (la_in),
         .io_access_in (io_access_in),
         .hit_out      (hit[g])
      );
   end

   select_encoder u_enc (
      .hit_in       (hit),
      .encoded_in   (format_r),
      .select_n_out (select_n),
      .encoded_out  (encoded)
   );

   // channels that hit and sit on the x-bus
   assign xbus_hit = hit & xbus_en_r;

   // dedicated selects
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         periph_select_n_out <= 3'h7;
      end else begin
         periph_select_n_out <= select_n;
      end
   end

   // encoded selects
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         encoded_select_lines_out <= ENC_IDLE;
      end else begin
         encoded_select_lines_out <= encoded;
      end
   end

   // transceiver enable
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         xbus_transceiver_oe_n_out <= 1'b1;
      end else begin
         xbus_transceiver_oe_n_out <= ~|xbus_hit;
      end
   end
endmodule

// file: core/gpcs_pkg.sv
package chip_select_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_MODE_SELECT   = 8'h40;
   localparam logic [7:0] IDX_CH0_LOW_ADDR  = 8'h64;
   localparam logic [7:0] IDX_CH0_HIGH_ADDR = 8'h65;
   localparam logic [7:0] IDX_CH0_MASK      = 8'h66;
   localparam logic [7:0] IDX_CH1_LOW_ADDR  = 8'h68;
   localparam logic [7:0] IDX_CH1_HIGH_ADDR = 8'h69;
   localparam logic [7:0] IDX_CH1_MASK      = 8'h6a;
   localparam logic [7:0] IDX_CH2_LOW_ADDR  = 8'h6c;
   localparam logic [7:0] IDX_CH2_HIGH_ADDR = 8'h6d;
   localparam logic [7:0] IDX_CH2_MASK      = 8'h6e;
   localparam logic [7:0] IDX_XBUS_CTRL     = 8'h6f;
   localparam logic [7:0] IDX_SELECT_FORMAT = 8'h7c;

   // index field of the byte address
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;

   // reset values
   localparam logic [7:0] RST_LOW_ADDR  = 8'h00;
   localparam logic [7:0] RST_HIGH_ADDR = 8'hc0;
   localparam logic [7:0] RST_MASK      = 8'h00;
   localparam logic [2:0] RST_XBUS_CTRL = 3'h0;
   localparam logic [7:0] RST_MODE_SEL  = 8'h00;
   localparam logic       RST_FORMAT    = 1'b0;

   // field positions and the x-bus enable width
   localparam int MODE_CH2_OFF_BIT = 4;
   localparam int XBUS_EN_W        = 3;
   localparam int FORMAT_ENC_BIT   = 0;

   // encoded select patterns
   localparam logic [2:0] ENC_CH0  = 3'h5;
   localparam logic [2:0] ENC_CH1  = 3'h6;
   localparam logic [2:0] ENC_IDLE = 3'h7;

   // ahb-lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// file: core/chan_match.sv
`timescale 1ns/100ps
module chan_match
   import chip_select_pkg::*;
(
   // programmed decode values
   input  wire logic [7:0]  high_addr_in,
   input  wire logic [7:0]  low_addr_in,
   input  wire logic [7:0]  low_mask_in,
   input  wire logic        chan_on_in,
   // access
   input  wire logic [15:0] la_in,
   input  wire logic        io_access_in,
   // result
   output logic             hit_out
);
   logic high_eq;
   logic low_eq;

   assign high_eq = (la_in[15:8] == high_addr_in);
   assign low_eq  = ((la_in[7:0] ^ low_addr_in) & ~low_mask_in)
                    == 8'h00;
   assign hit_out = io_access_in & chan_on_in & high_eq & low_eq;
endmodule

// file: core/select_encoder.sv
`timescale 1ns/100ps
module select_encoder
   import chip_select_pkg::*;
(
   // channel hits
   input  wire logic [2:0] hit_in,
   input  wire logic       encoded_in,
   // select patterns
   output logic [2:0]      select_n_out,
   output logic [2:0]      encoded_out
);
   always_comb begin
      select_n_out = 3'h7;
      encoded_out  = ENC_IDLE;
      if (encoded_in) begin
         if (hit_in[0]) begin
            encoded_out = ENC_CH0;
         end else if (hit_in[1]) begin
            encoded_out = ENC_CH1;
         end
      end else begin
         select_n_out = ~hit_in;
      end
   end
endmodule

// file: test/gpcs_chk.sv
`timescale 1ns/100ps
module chip_select_chk
   import chip_select_pkg::*;
#(
   parameter int ADDR_W = 32
)
(
   // bus side
   input  wire logic              clk_sys_in,
   input  wire logic              rst_b_in,
   input  wire logic              hsel_in,
   input  wire logic [ADDR_W-1:0] haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [31:0]       hwdata_in,
   input  wire logic              hready_in,
   input  wire logic [31:0]       hrdata_out,
   input  wire logic              hreadyout_out,
   input  wire logic              hresp_out,
   // decode side
   input  wire logic [15:0]       la_in,
   input  wire logic              io_access_in,
   input  wire logic [2:0]        periph_select_n_out,
   input  wire logic [2:0]        encoded_select_lines_out,
   input  wire logic              xbus_transceiver_oe_n_out
);
   logic [7:0] sh_r [256];
   logic [7:0] idx_r;
   logic       wr_r;
   logic       rd_r;
   logic [2:0] hit;
   wire        take = hsel_in && hready_in && htrans_in[1];
   wire        fmt  = sh_r[IDX_SELECT_FORMAT][FORMAT_ENC_BIT];

   function automatic logic [7:0] wmask(input logic [7:0] i);
      if (i == IDX_MODE_SELECT) return 8'hff;
      if (i == IDX_XBUS_CTRL) return 8'h07;
      if (i == IDX_SELECT_FORMAT) return 8'h01;
      if (i >= IDX_CH0_LOW_ADDR && i <= IDX_CH2_MASK && i[1:0] != 2'h3)
         return 8'hff;
      return 8'h00;
   endfunction

   // shadow copy of the register file
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < 256; i++) sh_r[i] <= 8'h00;
         for (int c = 0; c < 3; c++) sh_r[8'h65 + 4 * c] <= RST_HIGH_ADDR;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
      end else begin
         if (wr_r) sh_r[idx_r] <= hwdata_in[7:0] & wmask(idx_r);
         wr_r <= take && hwrite_in;
         rd_r <= take && !hwrite_in;
         if (take) idx_r <= haddr_in[IDX_MSB:IDX_LSB];
      end
   end

   always_comb begin
      for (int c = 0; c < 3; c++)
         hit[c] = io_access_in && la_in[15:8] == sh_r[8'h65 + 4 * c]
            && ((la_in[7:0] ^ sh_r[8'h64 + 4 * c])
                & ~sh_r[8'h66 + 4 * c]) == 8'h00;
      if (sh_r[IDX_MODE_SELECT][MODE_CH2_OFF_BIT]) hit[2] = 1'b0;
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   a_dedicated_sel: assert property (
      !fmt |=> periph_select_n_out == ~$past(hit))
      else $error("dedicated select mismatch");
   a_encoded_sel: assert property (
      fmt |=> encoded_select_lines_out == ($past(hit[0]) ? ENC_CH0 :
         $past(hit[1]) ? ENC_CH1 : ENC_IDLE))
      else $error("encoded select mismatch");
   a_encoded_only: assert property (
      fmt |=> periph_select_n_out == 3'h7)
      else $error("dedicated select active in encoded form");
   a_xbus_oe: assert property (
      1'b1 |=> xbus_transceiver_oe_n_out
         == !(|$past(hit & sh_r[IDX_XBUS_CTRL][2:0])))
      else $error("transceiver enable mismatch");
   a_no_io_idle: assert property (
      !io_access_in |=> periph_select_n_out == 3'h7
         && encoded_select_lines_out == ENC_IDLE && xbus_transceiver_oe_n_out)
      else $error("select active without i/o access");
   a_ch2_off: assert property (
      sh_r[IDX_MODE_SELECT][MODE_CH2_OFF_BIT] |=> periph_select_n_out[2])
      else $error("third channel decoded while disabled");
   a_read_data: assert property (
      rd_r |-> hrdata_out == {24'h0, sh_r[idx_r]})
      else $error("read data mismatch");
   a_bus_okay: assert property (
      hreadyout_out && hresp_out == HRESP_OKAY)
      else $error("bus not ready or not okay");
endmodule

bind general_purpose_chip_select_decoder
   chip_select_chk #(.ADDR_W(ADDR_W)) chk_u (
   .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in),
   .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
   .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .la_in(la_in),
   .io_access_in(io_access_in), .periph_select_n_out(periph_select_n_out),
   .encoded_select_lines_out(encoded_select_lines_out),
   .xbus_transceiver_oe_n_out(xbus_transceiver_oe_n_out));

// file: test/xbus_io_source.sv
`timescale 1ns/100ps
module xbus_io_source (
   // access request
   input  wire logic        clk_sys_in,
   input  wire logic        req_in,
   input  wire logic [15:0] addr_in,
   // cycle onto the decoder
   output logic [15:0]      la_out,
   output logic             io_out
);
   logic [15:0] idle_r = 16'h5a5a;
   // released lines keep toggling
   always @(posedge clk_sys_in) idle_r <= ~idle_r;
   assign io_out = req_in;
   assign la_out = req_in ? addr_in : idle_r;
endmodule

// file: test/gpcs_decoder_test.sv
`timescale 1ns/100ps
module general_purpose_chip_select_decoder_test
   import chip_select_pkg::*;
;
   logic        clk_sys_in = 1'b0;
   logic        rst_b_in   = 1'b0;
   logic        hsel       = 1'b0;
   logic        hwrite     = 1'b0;
   logic        req        = 1'b0;
   logic [1:0]  htrans     = 2'h0;
   logic [31:0] haddr      = 32'h0;
   logic [31:0] hwdata     = 32'h0;
   logic [15:0] addr       = 16'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, io, oe_n;
   logic [15:0] la;
   logic [2:0]  sel_n, enc;
   int          err_total   = 0;
   int          checks_done = 0;

   always #2 clk_sys_in = ~clk_sys_in;

   xbus_io_source src_u (.clk_sys_in(clk_sys_in), .req_in(req),
      .addr_in(addr), .la_out(la), .io_out(io));
   general_purpose_chip_select_decoder dut_u (.clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hreadyout), .hrdata_out(hrdata),
      .hreadyout_out(hreadyout), .hresp_out(hresp), .la_in(la),
      .io_access_in(io), .periph_select_n_out(sel_n),
      .encoded_select_lines_out(enc), .xbus_transceiver_oe_n_out(oe_n));

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_ready();
      int n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         err_total++;
         complete_run();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] idx, d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
      rd = hrdata;
   endtask

   task automatic rchk(input logic [7:0] idx, exp);
      bus(1'b0, idx, 8'h00);
      check("register read", {24'h0, exp}, rd);
   endtask

   task automatic prog(input int c, input logic [7:0] hi, lo, mk);
      bus(1'b1, IDX_CH0_HIGH_ADDR + 8'(4 * c), hi);
      bus(1'b1, IDX_CH0_LOW_ADDR + 8'(4 * c), lo);
      bus(1'b1, IDX_CH0_MASK + 8'(4 * c), mk);
      rchk(IDX_CH0_HIGH_ADDR + 8'(4 * c), hi);
      rchk(IDX_CH0_MASK + 8'(4 * c), mk);
   endtask

   // expected is {dedicated, encoded, oe_n}
   task automatic probe(input logic [15:0] a, input logic [6:0] exp);
      req <= 1'b1;
      addr <= a;
      @(posedge clk_sys_in);
      #1 check("decode", {25'h0, exp}, {25'h0, sel_n, enc, oe_n});
      @(posedge clk_sys_in);
      req <= 1'b0;
      @(posedge clk_sys_in);
      #1 check("idle", 32'h7f, {25'h0, sel_n, enc, oe_n});
      @(posedge clk_sys_in);
   endtask

   task automatic t_reset();
      for (int c = 0; c < 3; c++) begin
         rchk(IDX_CH0_LOW_ADDR + 8'(4 * c), RST_LOW_ADDR);
         rchk(IDX_CH0_HIGH_ADDR + 8'(4 * c), RST_HIGH_ADDR);
         rchk(IDX_CH0_MASK + 8'(4 * c), RST_MASK);
      end
      rchk(IDX_XBUS_CTRL, {5'h0, RST_XBUS_CTRL});
      bus(1'b1, 8'h70, 8'h5a);
      rchk(8'h70, 8'h00);
      $display("test reset_values done");
   endtask

   task automatic t_decode();
      prog(0, 8'h03, 8'hf0, 8'h00);
      probe(16'h03f0, 7'h6f);
      probe(16'h03f1, 7'h7f);
      probe(16'h13f0, 7'h7f);
      prog(0, 8'h03, 8'hf0, 8'h0f);
      probe(16'h03f7, 7'h6f);
      probe(16'h03e0, 7'h7f);
      prog(0, 8'h03, 8'h00, 8'hff);
      probe(16'h04ff, 7'h7f);
      probe(16'h03aa, 7'h6f);
      $display("test decode done");
   endtask

   task automatic t_xbus_ch2();
      prog(1, 8'h04, 8'h00, 8'hff);
      bus(1'b1, IDX_XBUS_CTRL, 8'hfa);
      rchk(IDX_XBUS_CTRL, 8'h02);
      probe(16'h0455, 7'h5e);
      probe(16'h03aa, 7'h6f);
      prog(2, 8'h05, 8'h00, 8'hff);
      probe(16'h0512, 7'h3f);
      bus(1'b1, IDX_MODE_SELECT, 8'h10);
      probe(16'h0512, 7'h7f);
      $display("test xbus_ch2 done");
   endtask

   task automatic t_encoded();
      bus(1'b1, IDX_SELECT_FORMAT, 8'h01);
      probe(16'h03aa, 7'h7b);
      probe(16'h0466, 7'h7c);
      $display("test encoded done");
   endtask

   initial begin
      repeat (10) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      @(posedge clk_sys_in);
      t_reset();
      t_decode();
      t_xbus_ch2();
      t_encoded();
      complete_run();
   end
endmodule
